// [verif/pmc_pin_host.sv]
`timescale 1ns/1ns
// host side of the mode pins; a released pin floats to the pull-up
module pmc_pin_host (
   input wire logic drive_in,
   input wire logic [1:0] code_in,
   output logic low_pin_out,
   output logic high_pin_out
);
   assign {high_pin_out, low_pin_out} = drive_in ? code_in : 2'b11;
endmodule

// [verif/pmc_top_props.sv]
`timescale 1ns/1ns
module pmc_top_props (
   input wire logic SYS_CLK_IN,
   input wire logic RESET_IN,
   input wire logic MODE_SELECT_LOW_PIN_IN,
   input wire logic MODE_SELECT_HIGH_PIN_IN,
   input wire logic [15:0] ADDR_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic [31:0] RDATA_OUT,
   input wire logic INTERRUPT_LINE_ONE_N_OUT,
   input wire logic INTERRUPT_LINE_ZERO_N_OUT,
   input wire logic [1:0] MODE_OUT
);
   logic [1:0] pins;
   assign pins = {MODE_SELECT_HIGH_PIN_IN, MODE_SELECT_LOW_PIN_IN};
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (RESET_IN);
   ////////////////////////////////////////
   // mode output lags the state by a cycle, hence the two-cycle antecedents
   a_reset_idle: assert property (disable iff (1'b0) RESET_IN |=> (RDATA_OUT == 32'h0 &&
      INTERRUPT_LINE_ONE_N_OUT && INTERRUPT_LINE_ZERO_N_OUT && MODE_OUT == 2'b11))
      else $error("outputs not idle after reset");
   a_dead_port: assert property ((RD_IN && MODE_OUT[1]) ##1 MODE_OUT[1] |->
      RDATA_OUT == 32'h0) else $error("read answered while port is off");
   a_pins_stable: assert property (($changed(MODE_OUT) && MODE_OUT == 2'b00) |->
      ($past(pins, 5) == 2'b00 && $past(pins, 6) == 2'b00)) else $error("mode taken early");
   a_done_irq: assert property (($changed(MODE_OUT) && MODE_OUT == 2'b01) |->
      ##[0:1] !INTERRUPT_LINE_ONE_N_OUT) else $error("no line one on power-up done");
   a_clear_done: assert property ((WR_IN && ADDR_IN == 16'he503 && WDATA_IN[15] &&
      WDATA_IN[0] && MODE_OUT == 2'b01 && $past(MODE_OUT) == 2'b01) |=> ##[0:1]
      INTERRUPT_LINE_ONE_N_OUT) else $error("line one not released by clear");
   a_wake_irq: assert property (($changed(MODE_OUT) && MODE_OUT == 2'b00 &&
      $past(MODE_OUT) != 2'b01) |-> ##[0:1] !INTERRUPT_LINE_ONE_N_OUT)
      else $error("no line one on reduced wake");
   a_zero_idle: assert property ((MODE_OUT != 2'b10 && $past(MODE_OUT) != 2'b10 &&
      $past(MODE_OUT, 2) != 2'b10) |-> INTERRUPT_LINE_ZERO_N_OUT)
      else $error("line zero low outside low-power");
   a_zero_early: assert property ($rose(MODE_OUT == 2'b10) |->
      INTERRUPT_LINE_ZERO_N_OUT [*8]) else $error("line zero before period end");
endmodule
bind pmc_top pmc_top_props u_props (.SYS_CLK_IN, .RESET_IN, .MODE_SELECT_LOW_PIN_IN,
   .MODE_SELECT_HIGH_PIN_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT,
   .INTERRUPT_LINE_ONE_N_OUT, .INTERRUPT_LINE_ZERO_N_OUT, .MODE_OUT);

// [verif/power_mode_controller_test.sv]
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("BAD %0t got %h want %h", $time, g, e); end end
module power_mode_controller_test import pmc_pkg::*; ;
   typedef struct {logic [15:0] a; logic [31:0] d; logic [31:0] e;} pmc_row_s;
   logic clk = 0, rst = 1, drv = 0, wr = 0, rd = 0, sv = 0, rv = 0;
   logic [1:0] code = 2'b11;
   logic [15:0] addr = 16'h0;
   logic [31:0] wdata = 32'h0;
   logic [59:0] cur = 60'h0, pos = 60'h0;
   logic [2:0] rsel = 3'h0;
   logic [23:0] rdat = 24'h0;
   wire logic lo, hi, l1_n, l0_n;
   wire logic [31:0] rdata;
   wire logic [1:0] mode;
   int error_cnt = 0, checks = 0, cyc = 0;
   // mode RO, unmapped dropped, narrow regs keep only low bits
   pmc_row_s rows[6] = '{'{16'he50b, 32'h8000, 32'h8000}, '{16'he618, 32'h0, 32'h0},
      '{16'hec00, 32'h103, 32'h3}, '{16'hec01, 32'h4, 32'h4},
      '{16'h1234, 32'hffff, 32'h0}, '{16'he700, 32'h0, 32'h1}};
   pmc_pin_host host_u (.drive_in(drv), .code_in(code), .low_pin_out(lo), .high_pin_out(hi));
   pmc_top #(.UNIT_CYCLES(20)) dut_u (.SYS_CLK_IN(clk), .RESET_IN(rst),
      .MODE_SELECT_LOW_PIN_IN(lo), .MODE_SELECT_HIGH_PIN_IN(hi), .ADDR_IN(addr),
      .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .CURRENT_SAMPLE_IN(cur),
      .POSITIVE_INPUT_IN(pos), .SAMPLE_VALID_IN(sv), .RMS_VALID_IN(rv), .RMS_SEL_IN(rsel),
      .RMS_DATA_IN(rdat), .INTERRUPT_LINE_ONE_N_OUT(l1_n), .INTERRUPT_LINE_ZERO_N_OUT(l0_n),
      .MODE_OUT(mode));
   ////////////////////////////////////////
   initial forever #10 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         summarize();
      end
   end
   task summarize;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task wr_reg(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_chk(input logic [15:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      `CHK(rdata, e)
   endtask
   // bounded waits: a stuck mode or line must not hang the run
   task set_mode(input logic [1:0] m);
      @(posedge clk);
      drv <= 1'b1;
      code <= m;
      repeat (400) begin
         @(negedge clk);
         if (mode === m) return;
      end
      error_cnt++;
      $display("BAD %0t mode wait", $time);
   endtask
   task wait_low(input bit zero, input int lim);
      repeat (lim) begin
         @(negedge clk);
         if ((zero ? l0_n : l1_n) === 1'b0) return;
      end
      error_cnt++;
      $display("BAD %0t line wait", $time);
   endtask
   task samples(input int n, input logic [59:0] c, input logic [59:0] p);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         cur <= c;
         pos <= i[0] ? p : 60'h0;
         sv <= 1'b1;
         @(posedge clk);
         sv <= 1'b0;
      end
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (20) @(negedge clk);
      `CHK(mode, 2'b11)
      `CHK({l1_n, l0_n}, 2'b11)
      set_mode(2'b01);
      wait_low(1'b0, 3);
      rd_chk(16'he503, 32'h8000);
      rd_chk(16'he618, 32'h1);
      @(posedge clk);
      rdat <= 24'h123456;
      rv <= 1'b1;
      @(posedge clk);
      rv <= 1'b0;
      rd_chk(16'h43c0, 32'h123456);
      foreach (rows[i]) begin
         wr_reg(rows[i].a, rows[i].d);
         rd_chk(rows[i].a, rows[i].e);
      end
      `CHK(l1_n, 1'b0)
      wr_reg(16'he503, 32'h8001);
      repeat (2) @(negedge clk);
      `CHK(l1_n, 1'b1)
      rd_chk(16'he503, 32'h0);
      set_mode(2'b10);
      rd_chk(16'hec00, 32'h0);
      samples(6, 60'h0, 60'h0);
      `CHK({l1_n, l0_n}, 2'b11)
      // only the positive terminal crosses; the differential sample stays zero
      samples(4, 60'h0, {20'h00700, 40'h0});
      wait_low(1'b0, 20);
      `CHK(l0_n, 1'b1)
      set_mode(2'b11);
      set_mode(2'b00);
      wait_low(1'b0, 3);
      samples(16, {20'h0, 20'hfff38, 20'h00064}, 60'h0);
      rd_chk(16'h43bc, 32'h64);
      rd_chk(16'h43bd, 32'hc8);
      rd_chk(16'h43be, 32'h0);
      wr_reg(16'hec00, 32'hff);
      set_mode(2'b01);
      rd_chk(16'hec00, 32'h3);
      rd_chk(16'hec01, 32'h4);
      rd_chk(16'he618, 32'h1);
      rd_chk(16'h43bc, 32'h64);
      wr_reg(16'hec01, 32'h0);
      wr_reg(16'he503, 32'h8001);
      set_mode(2'b10);
      repeat (150) @(negedge clk);
      `CHK(l0_n, 1'b1)
      wait_low(1'b1, 100);
      `CHK(l1_n, 1'b1)
      // reduced straight from normal: no wake pulse, averaging restarts
      set_mode(2'b01);
      wr_reg(16'he503, 32'h8000);
      set_mode(2'b00);
      repeat (3) @(negedge clk);
      `CHK(l1_n, 1'b1)
      samples(16, {40'h0, 20'h00032}, 60'h0);
      rd_chk(16'h43bc, 32'h32);
      // interrupt sub-mode, phase a crosses twice
      set_mode(2'b10);
      samples(4, 60'h0, {40'h0, 20'h00700});
      wait_low(1'b0, 250);
      `CHK(l0_n, 1'b1)
      summarize();
   end
endmodule

// [verilog/pmc_params.svh]
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

// clock
`define CLK_PERIOD_NS 20

// mode pin codes, {high pin, low pin}
`define PINS_NORMAL 2'b01
`define PINS_REDUCED 2'b00
`define PINS_LOWPWR 2'b10
`define PINS_SLEEP 2'b11
`define PIN_STABLE_CYCLES 4'h4

// power-up sequence
`define PUP_TIME_NS 2000
`define PUP_CYCLES ((`PUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// low-power measurement period, unit of 0.02 s
`define PERIOD_UNIT_NS 20000000
`define PERIOD_LAST_OFFSET 6'h09
`define TAMPER_OFFSET 6'h01

// register map
`define ADDR_STAT_ONE 16'he503
`define ADDR_MASK1 16'he50b
`define ADDR_CTRL 16'he618
`define ADDR_MODE 16'he700
`define ADDR_THRESH 16'hec00
`define ADDR_CFG2 16'hec01
`define ADDR_MEAN_ABS_A 16'h43bc
`define ADDR_MEAN_ABS_B 16'h43bd
`define ADDR_MEAN_ABS_C 16'h43be
`define ADDR_RMS_HI 13'h0878
`define RMS_COUNT 3'h6

// fields
`define BIT_PUP_DONE 15
`define BIT_RMS_EVT 0
`define BIT_LINE0_DIS 2
`define BIT_CAPTURE_EN 0
`define THR_CODE_MSB 2
`define THR_CODE_LSB 0
`define PERIOD_MSB 7
`define PERIOD_LSB 3

// reset values
`define CTRL_RST 32'h00000001
`define MASK_RST 32'h00000000
`define THRESH_RST 8'h00
`define CFG2_RST 8'h00

// threshold codes and peak levels
`define THR_CODE_71MV 3'h0
`define THR_CODE_1MV 3'h3
`define THR_CODE_0P47MV 3'h7
`define THR_LVL_71MV 20'h1e000
`define THR_LVL_1MV 20'h00600
`define THR_LVL_0P47MV 20'h002d0

// datapath widths
`define SAMPLE_W 20
`define ACC_W 24
`define MEAN_ABS_LOG2 4
`define MEAN_ABS_LAST 4'hf
`define CNT_W 6
`define CNT_MAX 6'h3f
`define RMS_W 24

`endif

// [verilog/pmc_phase.sv]
`timescale 1ns/1ns
`include "pmc_params.svh"

module pmc_phase
   import pmc_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   pmc_phase_if.chan ph
);

   pmc_sample_t abs_val;
   logic [`ACC_W-1:0] acc_reg;
   logic [`ACC_W-1:0] acc_next;
   logic [3:0] n_reg;
   pmc_sample_t mean_abs_reg;
   logic above_reg;
   logic [`CNT_W-1:0] count_reg;
   logic above;

   // most negative code saturates instead of wrapping
   always_comb begin
      if (!ph.sample[`SAMPLE_W-1]) begin
         abs_val = ph.sample;
      end else if (ph.sample[`SAMPLE_W-2:0] == '0) begin
         abs_val = '1;
      end else begin
         abs_val = pmc_sample_t'(-ph.sample);
      end
   end

   assign acc_next = acc_reg + {{(`ACC_W-`SAMPLE_W){1'b0}}, abs_val};
   assign above = ph.pos_sample > ph.threshold;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_in) begin
      if (rst_in || !ph.mean_abs_run) begin
         acc_reg <= '0;
         n_reg <= 4'h0;
      end else if (ph.valid) begin
         if (n_reg == `MEAN_ABS_LAST) begin
            acc_reg <= '0;
            n_reg <= 4'h0;
         end else begin
            acc_reg <= acc_next;
            n_reg <= n_reg + 4'h1;
         end
      end
   end

   // result survives mode changes, only a device reset clears it
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mean_abs_reg <= '0;
      end else if (ph.mean_abs_run && ph.valid && n_reg == `MEAN_ABS_LAST) begin
         mean_abs_reg <= acc_next[`ACC_W-1:`MEAN_ABS_LOG2];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_in) begin
      if (rst_in || ph.lp_clear) begin
         above_reg <= 1'b0;
         count_reg <= '0;
      end else if (ph.lp_run && ph.valid) begin
         above_reg <= above;
         if (above && !above_reg && count_reg != `CNT_MAX) begin
            count_reg <= count_reg + `TAMPER_OFFSET;
         end
      end
   end

   assign ph.mean_abs = mean_abs_reg;
   assign ph.count = count_reg;

endmodule

// [verilog/pmc_phase_if.sv]
`timescale 1ns/1ns
`include "pmc_params.svh"

interface pmc_phase_if;
   logic [`SAMPLE_W-1:0] sample;
   logic [`SAMPLE_W-1:0] pos_sample;
   logic valid;
   logic mean_abs_run;
   logic lp_run;
   logic lp_clear;
   logic [`SAMPLE_W-1:0] threshold;
   logic [`SAMPLE_W-1:0] mean_abs;
   logic [`CNT_W-1:0] count;

   modport ctrl (
      output sample, pos_sample, valid, mean_abs_run, lp_run, lp_clear, threshold,
      input mean_abs, count
   );
   modport chan (
      input sample, pos_sample, valid, mean_abs_run, lp_run, lp_clear, threshold,
      output mean_abs, count
   );
endinterface

// [verilog/pmc_pkg.sv]
package pmc_pkg;

   typedef enum logic [2:0] {
      ST_SLEEP,
      ST_PWRUP,
      ST_NORMAL,
      ST_REDUCED,
      ST_LOWPWR
   } pmc_state_e;

   typedef logic [19:0] pmc_sample_t;

endpackage

// [verilog/pmc_top.sv]
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`include "pmc_params.svh"

//
// Contract
// - pins decode normal 01, reduced 00, low-power 10, sleep 11.
// - undriven mode pins read high, so the device starts asleep.
// - entering normal restores control defaults, except threshold and second config.
// - power-up done pulls line one low and sets status bit 15.
// - done flag reads 0 during power-up, 1 once normal is entered.
// - writing one to status bit 15 clears it and releases line one.
// - done interrupt ignores mask bit 15.
// - reduced mode computes mean absolute value per phase into 20-bit registers.
// - reduced mode allows reads and silently drops every write.
// - mean-absolute results stay readable after returning to normal.
// - reduced from normal starts computation at once, results always readable.
// - reduced from low-power or sleep pulls line one low.
// - low-power compares phase currents against threshold; crossing declares tamper.
// - all phases below threshold for whole period reports plain outage.
// - host port is dead in low-power mode.
// - low-power has interrupt and line-one-only sub-modes, interrupt by default.
// - threshold uses peak of positive terminal, not differential value.
// - rms results kept only in normal, apart from mean-absolute values.
// - counter at least period plus one at period end pulls line one.
// - all counters below period plus one at period end pulls line zero.
// - interrupt sub-mode period is 0.02 s times field plus ten.
// - second config bit 2 disables line zero, line-one-only sub-mode.
module pmc_top
   import pmc_pkg::*;
#(
   parameter bit FULL_FEATURED = 1'b1,
   parameter int unsigned UNIT_CYCLES = `PERIOD_UNIT_NS / `CLK_PERIOD_NS
) (
   input wire logic SYS_CLK_IN,
   input wire logic RESET_IN,
   input wire logic MODE_SELECT_LOW_PIN_IN,
   input wire logic MODE_SELECT_HIGH_PIN_IN,
   input wire logic [15:0] ADDR_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [31:0] RDATA_OUT,
   input wire logic [3*`SAMPLE_W-1:0] CURRENT_SAMPLE_IN,
   input wire logic [3*`SAMPLE_W-1:0] POSITIVE_INPUT_IN,
   input wire logic SAMPLE_VALID_IN,
   input wire logic RMS_VALID_IN,
   input wire logic [2:0] RMS_SEL_IN,
   input wire logic [`RMS_W-1:0] RMS_DATA_IN,
   output logic INTERRUPT_LINE_ONE_N_OUT,
   output logic INTERRUPT_LINE_ZERO_N_OUT,
   output logic [1:0] MODE_OUT
);

   localparam logic [7:0] PUP_LAST = 8'(`PUP_CYCLES - 1);
   localparam logic [19:0] UNIT_LAST = 20'(UNIT_CYCLES - 1);

   logic [1:0] pin_s1_reg;
   logic [1:0] pin_s2_reg;
   logic [1:0] cand_reg;
   logic [3:0] stab_cnt_reg;
   logic [1:0] pins_reg;
   pmc_state_e state_reg;
   pmc_state_e state_next;
   pmc_state_e want;
   logic [7:0] pup_cnt_reg;
   logic enter_normal;
   logic start_pwrup;
   logic enter_reduced_low;
   logic wr_ok;
   logic rd_ok;
   logic rms_cap;
   logic power_up_done_flag_reg;
   logic rms_evt_reg;
   logic [31:0] mask_reg;
   logic [31:0] ctrl_reg;
   logic [7:0] tamper_threshold_reg;
   logic [7:0] second_config_reg;
   logic [`RMS_W-1:0] rms_reg [0:5];
   logic mean_abs_start_reg;
   logic [19:0] lp_unit_reg;
   logic [5:0] lp_units_reg;
   logic lp_done_reg;
   logic tamper_reg;
   logic no_tamper_reg;
   logic unit_tick;
   logic period_end;
   logic line_zero_disable;
   logic [5:0] period_count_field;
   logic [5:0] need_cnt;
   logic [2:0] hit;
   logic any_hit;
   logic [`SAMPLE_W-1:0] thr_lvl;
   logic [31:0] rd_mux;
   logic [1:0] mode_code;

   ////////////////////////////////////////////////////////////////////////
   // mode pins: first stage feeds only the second
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         pin_s1_reg <= `PINS_SLEEP;
         pin_s2_reg <= `PINS_SLEEP;
      end else begin
         pin_s1_reg <= {MODE_SELECT_HIGH_PIN_IN, MODE_SELECT_LOW_PIN_IN};
         pin_s2_reg <= pin_s1_reg;
      end
   end

   // a glitch on a pin restarts the stability count
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         cand_reg <= `PINS_SLEEP;
         stab_cnt_reg <= 4'h0;
         pins_reg <= `PINS_SLEEP;
      end else if (pin_s2_reg != cand_reg) begin
         cand_reg <= pin_s2_reg;
         stab_cnt_reg <= 4'h0;
      end else if (stab_cnt_reg != `PIN_STABLE_CYCLES) begin
         stab_cnt_reg <= stab_cnt_reg + 4'h1;
      end else begin
         pins_reg <= cand_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // lean variants fold the two battery modes into sleep
   always_comb begin
      case (pins_reg)
         `PINS_NORMAL: begin
            want = ST_NORMAL;
         end
         `PINS_REDUCED: begin
            want = FULL_FEATURED ? ST_REDUCED : ST_SLEEP;
         end
         `PINS_LOWPWR: begin
            want = FULL_FEATURED ? ST_LOWPWR : ST_SLEEP;
         end
         default: begin
            want = ST_SLEEP;
         end
      endcase
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_NORMAL: begin
            state_next = want;
         end
         ST_PWRUP: begin
            if (want != ST_NORMAL) begin
               state_next = want;
            end else if (pup_cnt_reg == PUP_LAST) begin
               state_next = ST_NORMAL;
            end
         end
         default: begin
            state_next = (want == ST_NORMAL) ? ST_PWRUP : want;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         state_reg <= ST_SLEEP;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN || state_reg != ST_PWRUP) begin
         pup_cnt_reg <= 8'h00;
      end else begin
         pup_cnt_reg <= pup_cnt_reg + 8'h01;
      end
   end

   assign enter_normal = state_reg == ST_PWRUP && state_next == ST_NORMAL;
   assign start_pwrup = state_next == ST_PWRUP && state_reg != ST_PWRUP;
   assign enter_reduced_low = state_next == ST_REDUCED && state_reg != ST_REDUCED &&
                              state_reg != ST_NORMAL;

   ////////////////////////////////////////////////////////////////////////
   // host port gating
   assign wr_ok = WR_IN && state_reg == ST_NORMAL;
   assign rd_ok = state_reg == ST_NORMAL || state_reg == ST_REDUCED;
   assign rms_cap = RMS_VALID_IN && state_reg == ST_NORMAL &&
                    ctrl_reg[`BIT_CAPTURE_EN] && RMS_SEL_IN < `RMS_COUNT;

   // set wins over a clear in the same cycle
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         power_up_done_flag_reg <= 1'b0;
      end else if (enter_normal) begin
         power_up_done_flag_reg <= 1'b1;
      end else if (start_pwrup) begin
         power_up_done_flag_reg <= 1'b0;
      end else if (wr_ok && ADDR_IN == `ADDR_STAT_ONE && WDATA_IN[`BIT_PUP_DONE]) begin
         power_up_done_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN || enter_normal) begin
         rms_evt_reg <= 1'b0;
      end else if (rms_cap) begin
         rms_evt_reg <= 1'b1;
      end else if (wr_ok && ADDR_IN == `ADDR_STAT_ONE && WDATA_IN[`BIT_RMS_EVT]) begin
         rms_evt_reg <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN || enter_normal) begin
         mask_reg <= `MASK_RST;
         ctrl_reg <= `CTRL_RST;
      end else if (wr_ok) begin
         if (ADDR_IN == `ADDR_MASK1) begin
            mask_reg <= WDATA_IN;
         end
         if (ADDR_IN == `ADDR_CTRL) begin
            ctrl_reg <= WDATA_IN;
         end
      end
   end

   // these two survive the return to normal
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         tamper_threshold_reg <= `THRESH_RST;
         second_config_reg <= `CFG2_RST;
      end else if (wr_ok) begin
         if (ADDR_IN == `ADDR_THRESH) begin
            tamper_threshold_reg <= WDATA_IN[7:0];
         end
         if (ADDR_IN == `ADDR_CFG2) begin
            second_config_reg <= WDATA_IN[7:0];
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         for (int i = 0; i < 6; i++) begin
            rms_reg[i] <= '0;
         end
      end else if (rms_cap) begin
         rms_reg[RMS_SEL_IN] <= RMS_DATA_IN;
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         mean_abs_start_reg <= 1'b0;
      end else if (enter_reduced_low) begin
         mean_abs_start_reg <= 1'b1;
      end else if (state_reg != ST_REDUCED) begin
         mean_abs_start_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // low-power tamper monitor
   assign line_zero_disable = second_config_reg[`BIT_LINE0_DIS];
   assign period_count_field = {1'b0, tamper_threshold_reg[`PERIOD_MSB:`PERIOD_LSB]};
   assign need_cnt = period_count_field + `TAMPER_OFFSET;
   assign unit_tick = lp_unit_reg == UNIT_LAST;
   assign period_end = unit_tick &&
                       lp_units_reg == period_count_field + `PERIOD_LAST_OFFSET;
   assign any_hit = |hit;

   always_comb begin
      case (tamper_threshold_reg[`THR_CODE_MSB:`THR_CODE_LSB])
         `THR_CODE_1MV: begin
            thr_lvl = `THR_LVL_1MV;
         end
         `THR_CODE_0P47MV: begin
            thr_lvl = `THR_LVL_0P47MV;
         end
         default: begin
            thr_lvl = `THR_LVL_71MV;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN || state_reg != ST_LOWPWR) begin
         lp_unit_reg <= 20'h00000;
         lp_units_reg <= 6'h00;
      end else if (unit_tick) begin
         lp_unit_reg <= 20'h00000;
         lp_units_reg <= lp_units_reg + 6'h01;
      end else begin
         lp_unit_reg <= lp_unit_reg + 20'h00001;
      end
   end

   // line-one-only keeps counting for the whole stay in low power
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN || state_reg != ST_LOWPWR) begin
         lp_done_reg <= 1'b0;
         tamper_reg <= 1'b0;
         no_tamper_reg <= 1'b0;
      end else if (line_zero_disable) begin
         tamper_reg <= tamper_reg | any_hit;
      end else if (period_end && !lp_done_reg) begin
         lp_done_reg <= 1'b1;
         tamper_reg <= any_hit;
         no_tamper_reg <= !any_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // three phase channels
   pmc_phase_if ph_if[3] ();

   for (genvar g = 0; g < 3; g++) begin : g_phase
      assign ph_if[g].sample = CURRENT_SAMPLE_IN[g*`SAMPLE_W +: `SAMPLE_W];
      assign ph_if[g].pos_sample = POSITIVE_INPUT_IN[g*`SAMPLE_W +: `SAMPLE_W];
      assign ph_if[g].valid = SAMPLE_VALID_IN;
      assign ph_if[g].mean_abs_run = state_reg == ST_REDUCED;
      assign ph_if[g].lp_clear = state_reg != ST_LOWPWR;
      assign ph_if[g].lp_run = state_reg == ST_LOWPWR && (line_zero_disable || !lp_done_reg);
      assign ph_if[g].threshold = thr_lvl;
      assign hit[g] = ph_if[g].count >= need_cnt;

      pmc_phase u_phase (
         .clk_in(SYS_CLK_IN),
         .rst_in(RESET_IN),
         .ph(ph_if[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // read path; unmapped addresses read zero
   always_comb begin
      rd_mux = 32'h00000000;
      case (ADDR_IN)
         `ADDR_STAT_ONE: begin
            rd_mux[`BIT_PUP_DONE] = power_up_done_flag_reg;
            rd_mux[`BIT_RMS_EVT] = rms_evt_reg;
         end
         `ADDR_MASK1: begin
            rd_mux = mask_reg;
         end
         `ADDR_CTRL: begin
            rd_mux = ctrl_reg;
         end
         `ADDR_MODE: begin
            rd_mux[1:0] = mode_code;
         end
         `ADDR_THRESH: begin
            rd_mux[7:0] = tamper_threshold_reg;
         end
         `ADDR_CFG2: begin
            rd_mux[7:0] = second_config_reg;
         end
         `ADDR_MEAN_ABS_A: begin
            rd_mux[`SAMPLE_W-1:0] = ph_if[0].mean_abs;
         end
         `ADDR_MEAN_ABS_B: begin
            rd_mux[`SAMPLE_W-1:0] = ph_if[1].mean_abs;
         end
         `ADDR_MEAN_ABS_C: begin
            rd_mux[`SAMPLE_W-1:0] = ph_if[2].mean_abs;
         end
         default: begin
            if (ADDR_IN[15:3] == `ADDR_RMS_HI && ADDR_IN[2:0] < `RMS_COUNT) begin
               rd_mux[`RMS_W-1:0] = rms_reg[ADDR_IN[2:0]];
            end
         end
      endcase
   end

   // data stand for exactly one cycle after the strobe
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         RDATA_OUT <= 32'h00000000;
      end else if (RD_IN && rd_ok) begin
         RDATA_OUT <= rd_mux;
      end else begin
         RDATA_OUT <= 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // power-up sequence reports as sleep
   always_comb begin
      case (state_reg)
         ST_NORMAL: begin
            mode_code = `PINS_NORMAL;
         end
         ST_REDUCED: begin
            mode_code = `PINS_REDUCED;
         end
         ST_LOWPWR: begin
            mode_code = `PINS_LOWPWR;
         end
         default: begin
            mode_code = `PINS_SLEEP;
         end
      endcase
   end

   // mask bit 15 is never consulted
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         INTERRUPT_LINE_ONE_N_OUT <= 1'b1;
         INTERRUPT_LINE_ZERO_N_OUT <= 1'b1;
         MODE_OUT <= `PINS_SLEEP;
      end else begin
         INTERRUPT_LINE_ONE_N_OUT <= !(power_up_done_flag_reg ||
                                       mean_abs_start_reg || tamper_reg ||
                                       (rms_evt_reg && mask_reg[`BIT_RMS_EVT]));
         INTERRUPT_LINE_ZERO_N_OUT <= !(no_tamper_reg && !line_zero_disable);
         MODE_OUT <= mode_code;
      end
   end

endmodule

// [verilog/pmc_unused.sv]
`timescale 1ns/1ns
